//--- logic/i2c_mem_slave.sv
// How it works
// - Each received data byte is written into the array right after its eighth bit.
// - No busy state; a new transaction is accepted directly after a write.
// - Bits are sampled at serial clock rise; outgoing data changes at its fall.
// - Write lock high blocks writes everywhere; low leaves all locations writable.
// - Write lock input has no pull-down here; an unconnected pin must read low at the board.
// - Serial data is open drain: pulled low or released, never driven high.
// - Storage is 2048 locations of eight bits each.
// - Serial clock up to 1 MHz, plus 100 kHz and 400 kHz timings.
// - First byte upper nibble must match the type code to get a response.
// - First byte bits 3-1 pick a 256-byte page, bit 0 is direction.
// - The 11-bit address latch increments after each data byte and wraps 7FFh to 000h.
// - Both directions load the page; a write loads the low address byte from the word byte, reads continue on.
`timescale 1ns/1ps
`include "i2c_mem_cfg.svh"

module i2c_mem_slave #(
    parameter int ADDR_W = `MEM_ADDR_W
) (
    // System clock and reset.
    input  wire logic clock,
    input  wire logic rst_n,
    // Serial bus pins.
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    // Write lock pin.
    input  wire logic wr_lock
);
    import i2c_mem_pkg::*;

    localparam int DW = `MEM_DATA_W;

    initial begin
        if (ADDR_W != `MEM_ADDR_W) begin
            $error("Address width must match the page and word fields.");
        end
        if (`SCL_FAST_CYC < 8) begin
            $error("System clock too slow for the fastest serial clock.");
        end
    end

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [1:0] lock_sync_reg;
    logic       scl_d_reg;
    logic       sda_d_reg;

    // Pins come from outside this clock; two flops before use.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_sync_reg  <= 2'h3;
            sda_sync_reg  <= 2'h3;
            lock_sync_reg <= 2'h0;
            scl_d_reg     <= 1'b1;
            sda_d_reg     <= 1'b1;
        end else begin
            scl_sync_reg  <= {scl_sync_reg[0], scl_in};
            sda_sync_reg  <= {sda_sync_reg[0], sda_in};
            lock_sync_reg <= {lock_sync_reg[0], wr_lock};
            scl_d_reg     <= scl_sync_reg[1];
            sda_d_reg     <= sda_sync_reg[1];
        end
    end

    logic scl_s;
    logic sda_s;
    logic lock_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_s      = scl_sync_reg[1];
    assign sda_s      = sda_sync_reg[1];
    // An unconnected pin reads low at the board; the block treats low as writable.
    assign lock_s     = lock_sync_reg[1];
    assign scl_rise   = scl_s & ~scl_d_reg;
    assign scl_fall   = ~scl_s & scl_d_reg;
    assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    slave_state_t      state_reg;
    slave_state_t      after_ack_reg;
    logic [3:0]        bit_cnt_reg;
    logic [DW-1:0]     shift_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              is_read_reg;
    logic              ack_drive_reg;
    logic              mem_we;
    logic [DW-1:0]     mem_rdata;

    function automatic logic type_match(input logic [DW-1:0] b);
        return b[`TYPE_MSB:`TYPE_LSB] == `TYPE_CODE;
    endfunction

    logic byte_done;
    logic [DW-1:0] rx_byte;
    assign byte_done = scl_rise && (bit_cnt_reg == 4'h7);
    assign rx_byte   = {shift_reg[DW-2:0], sda_s};

    // Bit counter and receive shifter; a start or stop restarts framing.
    always_ff @(posedge clock) begin
        if (!rst_n || start_cond || stop_cond) begin
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
        end else if (state_reg == ST_ACK) begin
            bit_cnt_reg <= 4'h0;
        end else if (scl_rise && state_reg != ST_IDLE) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= (bit_cnt_reg == 4'h7) ? 4'h8 : bit_cnt_reg + 4'h1;
        end
    end

    // Transaction sequencing; no busy state exists after a write.
    always_ff @(posedge clock) begin
        if (!rst_n || stop_cond) begin
            state_reg     <= ST_IDLE;
            after_ack_reg <= ST_IDLE;
            is_read_reg   <= 1'b0;
        end else if (start_cond) begin
            state_reg <= ST_DEVAD;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_IDLE;
                end
                ST_DEVAD: begin
                    if (byte_done) begin
                        if (type_match(rx_byte)) begin
                            is_read_reg   <= rx_byte[`DIR_BIT];
                            after_ack_reg <= rx_byte[`DIR_BIT] ? ST_RDATA : ST_WORD;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        state_reg <= ST_ACK;
                    end
                end
                ST_WORD, ST_WDATA: begin
                    if (byte_done) begin
                        after_ack_reg <= ST_WDATA;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        state_reg <= ST_ACK;
                    end
                end
                ST_RDATA: begin
                    if (scl_fall && bit_cnt_reg == 4'h8) begin
                        state_reg <= ST_ACK;
                    end
                end
                // The ninth slot lasts until the next fall, so the line never moves while high.
                ST_ACK: begin
                    if (scl_rise && is_read_reg) begin
                        after_ack_reg <= sda_s ? ST_IDLE : ST_RDATA;
                    end else if (scl_fall) begin
                        state_reg <= after_ack_reg;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Address latch: page from the first byte, word byte on writes, wrap at the top.
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_reg <= '0;
        end else if (state_reg == ST_DEVAD && byte_done && type_match(rx_byte)) begin
            addr_reg[ADDR_W-1:DW] <= rx_byte[`PAGE_MSB:`PAGE_LSB];
        end else if (state_reg == ST_WORD && byte_done) begin
            addr_reg[DW-1:0] <= rx_byte;
        end else if ((state_reg == ST_WDATA || state_reg == ST_RDATA) && byte_done) begin
            addr_reg <= addr_reg + ADDR_W'(1);
        end
    end

    // Commit the byte at once; a lock only suppresses the store.
    assign mem_we = (state_reg == ST_WDATA) && byte_done && !lock_s;

    byte_store #(
        .DEPTH  (`MEM_DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (DW)
    ) u_store (
        .clock   (clock),
        .wr_en   (mem_we),
        .wr_addr (addr_reg),
        .wr_data (rx_byte),
        .rd_addr (addr_reg),
        .rd_data (mem_rdata)
    );

    // Output driver updates on the serial clock fall; a start or stop clears it.
    logic [DW-1:0] tx_reg;
    always_ff @(posedge clock) begin
        if (!rst_n || start_cond || stop_cond) begin
            ack_drive_reg <= 1'b0;
            tx_reg        <= 8'hff;
        end else if (scl_fall) begin
            if (state_reg == ST_ACK) begin
                ack_drive_reg <= 1'b0;
                if (after_ack_reg == ST_RDATA) begin
                    tx_reg <= mem_rdata;
                end
            end else if (state_reg == ST_RDATA) begin
                if (bit_cnt_reg != 4'h8) begin
                    tx_reg <= {tx_reg[DW-2:0], 1'b1};
                end
            end else if (state_reg != ST_IDLE && bit_cnt_reg == 4'h8) begin
                ack_drive_reg <= 1'b1;
            end
        end
    end

    // The last read bit stays on the line until the fall, so no false stop appears.
    logic pull_low;
    assign pull_low = ack_drive_reg || (state_reg == ST_RDATA && !tx_reg[DW-1]);
    // Open drain: the output level is always low, only the enable moves.
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~pull_low;

    // Assertions.
    sequence s_locked_byte;
        state_reg == ST_WDATA && byte_done && lock_s;
    endsequence

    lock_blocks_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_locked_byte |-> !mem_we) else $error("Write reached array while locked.");
    write_commits_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == ST_WDATA && byte_done && !lock_s) |-> mem_we)
        else $error("Received byte not committed.");
    never_high_a: assert property (@(posedge clock) disable iff (!rst_n)
        sda_out == 1'b0) else $error("Data line driven high.");
    drive_on_fall_a: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(sda_oe_n) |-> $past(scl_fall || start_cond || stop_cond))
        else $error("Data line moved off a clock fall.");
    addr_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == ST_RDATA && byte_done && addr_reg == 11'h7ff) |=> addr_reg == 11'h000)
        else $error("Address did not wrap.");
    locked_still_acks_a: assert property (@(posedge clock) disable iff (!rst_n)
        (s_locked_byte ##[1:8] scl_fall) |=> ack_drive_reg && state_reg == ST_ACK)
        else $error("Locked write byte not acknowledged.");
    type_mismatch_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_reg == ST_DEVAD && byte_done && !type_match(rx_byte) && !start_cond && !stop_cond)
        |=> state_reg == ST_IDLE) else $error("Foreign type code answered.");
    start_ready_a: assert property (@(posedge clock) disable iff (!rst_n)
        (start_cond && !stop_cond) |=> state_reg == ST_DEVAD)
        else $error("Start not accepted.");
endmodule

//--- logic/i2c_mem_cfg.svh
`ifndef I2C_MEM_CFG_SVH
`define I2C_MEM_CFG_SVH

// Byte count and width of the storage array.
`define MEM_DEPTH      2048
`define MEM_ADDR_W     11
`define MEM_DATA_W     8
// Position of the fields in the first byte after a start.
`define TYPE_MSB       7
`define TYPE_LSB       4
`define PAGE_MSB       3
`define PAGE_LSB       1
`define DIR_BIT        0
// Fixed device-type code; the value is arbitrary.
`define TYPE_CODE      4'h5
// Bus timings served: periods in ns of the fastest and the legacy rates.
`define SCL_FAST_NS    1000
`define SCL_STD_NS     10000
`define SCL_FM_NS      2500
`define CLOCK_NS       100
// Clock cycles per serial clock period at the fastest rate (round down).
`define SCL_FAST_CYC   (`SCL_FAST_NS / `CLOCK_NS)

`endif

//--- logic/i2c_mem_pkg.sv
package i2c_mem_pkg;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_DEVAD = 6'h02,
        ST_WORD  = 6'h04,
        ST_WDATA = 6'h08,
        ST_RDATA = 6'h10,
        ST_ACK   = 6'h20
    } slave_state_t;
endpackage

//--- logic/byte_store.sv
`timescale 1ns/1ps
`include "i2c_mem_cfg.svh"

module byte_store #(
    parameter int DEPTH  = `MEM_DEPTH,
    parameter int ADDR_W = `MEM_ADDR_W,
    parameter int DATA_W = `MEM_DATA_W
) (
    // Clock.
    input  wire logic              clock,
    // Write port.
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    // Registered read port.
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] cells [DEPTH];

    initial begin
        if (DEPTH != (1 << ADDR_W)) begin
            $error("Depth must fill the address space.");
        end
    end

    always_ff @(posedge clock) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= cells[rd_addr];
    end
endmodule

//--- tb/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
    // Clock and bus.
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // The clock rests high and the line released until the first frame.
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // Four clocks low, four high; data moves only while the clock is low.
    task automatic xfer(input logic b, output logic s);
        repeat (2) @(negedge clock);
        sda_low = !b;
        repeat (2) @(negedge clock);
        scl = 1'b1;
        repeat (3) @(negedge clock);
        s = sda_line;
        repeat (1) @(negedge clock);
        scl = 1'b0;
    endtask
    // Start or stop; the clock stands high between frames.
    task automatic cond(input logic is_start);
        repeat (2) @(negedge clock);
        sda_low = !is_start;
        repeat (2) @(negedge clock);
        scl = 1'b1;
        repeat (4) @(negedge clock);
        sda_low = is_start;
        repeat (4) @(negedge clock);
        scl = !is_start;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = !s;
    endtask
    task automatic get(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, s);
            d[i] = s;
        end
        xfer(!ack, s);
    endtask
endmodule

//--- tb/i2c_mem_slave_tb_top.sv
`timescale 1ns/1ps
`include "i2c_mem_cfg.svh"
module i2c_mem_slave_tb_top;
    logic       clock, rst_n, wr_lock, scl, sda_low;
    logic       sda_out, sda_oe_n, sda_line;
    logic [7:0] wbuf[4];
    int         fails;
    int         samples_checked;
    // Pull-up: the line is low only while some party pulls it.
    assign sda_line = (sda_low || (sda_oe_n === 1'b0 && !sda_out)) ? 1'b0 : 1'b1;
    always #50 clock = ~clock;
    i2c_mem_slave i_dut (
        .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .wr_lock(wr_lock)
    );
    i2c_master_model i_master (
        .clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
    );
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(negedge clock) begin
        if (sda_oe_n === 1'b0 && sda_out !== 1'b0) begin
            fails++;
            $display("[FAIL] sda_out expected 0 seen %b", sda_out);
        end
    end
    // A count of zero only moves the address latch.
    task automatic wr(input logic [2:0] pg, input logic [7:0] w, input int n);
        logic a;
        i_master.cond(1'b1);
        i_master.put({`TYPE_CODE, pg, 1'b0}, a);
        chk("wr dev ack", 8'h01, {7'h0, a});
        i_master.put(w, a);
        chk("word ack", 8'h01, {7'h0, a});
        for (int i = 0; i < n; i++) begin
            i_master.put(wbuf[i], a);
            chk("data ack", 8'h01, {7'h0, a});
        end
        i_master.cond(1'b0);
    endtask
    task automatic rd_chk(input logic [2:0] pg, input int n);
        logic       a;
        logic [7:0] d;
        i_master.cond(1'b1);
        i_master.put({`TYPE_CODE, pg, 1'b1}, a);
        chk("rd dev ack", 8'h01, {7'h0, a});
        for (int i = 0; i < n; i++) begin
            i_master.get(i < n - 1, d);
            chk("rd data", wbuf[i], d);
        end
        i_master.cond(1'b0);
    endtask
    // Next transaction starts right after the stop, with no polling.
    task automatic sc_write_read(input logic [2:0] pg, input logic [7:0] w, input int n);
        wr(pg, w, n);
        wr(pg, w, 0);
        rd_chk(pg, n);
    endtask
    task automatic sc_foreign();
        logic a;
        i_master.cond(1'b1);
        i_master.put({4'h6, 3'h0, 1'b0}, a);
        chk("foreign ack", 8'h00, {7'h0, a});
        i_master.cond(1'b0);
    endtask
    task automatic sc_lock();
        wbuf = '{8'h01, 8'h02, 8'h03, 8'h00};
        wr(3'h0, 8'h10, 3);
        wr_lock = 1'b1;
        wbuf = '{8'hee, 8'hef, 8'h00, 8'h00};
        wr(3'h0, 8'h10, 2);
        wr_lock = 1'b0;
        wbuf[0] = 8'h03;
        rd_chk(3'h0, 1);
        wbuf = '{8'h01, 8'h02, 8'h03, 8'h00};
        wr(3'h0, 8'h10, 0);
        rd_chk(3'h0, 3);
    endtask
    initial begin
        clock = 1'b0;
        rst_n = 1'b0;
        wr_lock = 1'b0;
        fails = 0;
        samples_checked = 0;
        repeat (6) @(negedge clock);
        chk("oe in reset", 8'h01, {7'h0, sda_oe_n});
        rst_n = 1'b1;
        repeat (6) @(negedge clock);
        sc_foreign();
        wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
        sc_write_read(3'h3, 8'ha5, 3);
        wbuf = '{8'hc3, 8'h3c, 8'h00, 8'h00};
        sc_write_read(3'h7, 8'hff, 2);
        sc_lock();
        close_out();
    end
endmodule
